/* src/adcd_pkg.sv */
// constants, types and decode helpers for the serial configuration decoder
//
// How it works
// - config word is 13 bits, channel then config
// - reset picks ch0+/ch1-, 50/60 rejection, 1x
// - first conversion starts by itself after reset
// - leading 000 or 100 ignores rest, keeps all
// - leading 101 loads next five bits as channel
// - single-ended 0 pairs channels, odd swaps polarity
// - single-ended 1 uses one channel against common
// - config enable 0 keeps previous configuration
// - config enable 1 loads temp, reject, speed bits
// - temp select converts internal sensor instead
// - reject bits: 00 both, 01 50Hz, 10 60Hz
// - speed 0 is 1x with calibration, 1 is 2x
// - temp select forces 1x, ignores speed bit
// - configuration holds until next 101 with enable
// - result from msb to bit 5, five sub bits
// - 2x underrange code is 0X0FFFFXXX
// - 2x zero code sign is free
// - input bits sampled on rising clock, select low
// - abort before 8 drops word, before 16 config
// - first frame bit low once conversion completes
package adcd_pkg;
   // =============================================
   // sizes and timing
   localparam int WORD_BITS = 13;
   localparam int CNT_W = 12;
   localparam int CLK_PERIOD_NS = 50;
   localparam int CONV_TIME_US = 100;
   localparam int CONV_CYCLES = (CONV_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam logic [CNT_W-1:0] CONV_LOAD_1X = CNT_W'(CONV_CYCLES - 1);
   localparam logic [CNT_W-1:0] CONV_LOAD_2X = CNT_W'(CONV_CYCLES / 2 - 1);
   localparam logic [5:0] CHAN_LOAD_FALLS = 6'h08;
   localparam logic [5:0] CFG_LOAD_FALLS = 6'h10;
   localparam logic [5:0] FRAME_FALLS = 6'h20;
   // =============================================
   // word field positions
   localparam int POS_EN = 10;
   localparam int POS_CHAN_HI = 9;
   localparam int POS_CHAN_LO = 5;
   localparam int POS_CFG_EN = 4;
   localparam int POS_TEMP = 3;
   localparam int POS_REJ_HI = 2;
   localparam int POS_REJ_LO = 1;
   localparam int POS_RATE = 0;
   localparam logic [2:0] LEAD_LOAD = 3'h5;
   // =============================================
   // reset values
   localparam logic [4:0] RST_CHAN = 5'h00;
   localparam logic RST_TEMP = 1'b0;
   localparam logic RST_REJ_HI = 1'b0;
   localparam logic RST_REJ_LO = 1'b0;
   localparam logic RST_RATE = 1'b0;
   // =============================================
   // result frame
   localparam logic [31:0] UNDER_AND = 32'h00000FFF;
   localparam logic [31:0] UNDER_OR = 32'h0FFFF000;
   // =============================================
   // apb offsets
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_RESULT = 8'h04;
   localparam logic [7:0] ADDR_SHADOW = 8'h08;
   localparam logic [7:0] ADDR_ACTIVE = 8'h0C;
   // =============================================
   // types
   typedef enum logic [1:0] {
      st_convert,
      st_sleep,
      st_io
   } adcd_state_type;
   // =============================================
   // channel decode, bit 4 is the common pin
   function automatic logic [4:0] chan_pos(input logic [4:0] c);
      logic [4:0] r;
      r = 5'h00;
      if (c[4]) begin
         r[{c[0], c[3]}] = 1'b1;
      end else begin
         r[{c[0], c[3]}] = 1'b1;
      end
      return r;
   endfunction : chan_pos

   function automatic logic [4:0] chan_neg(input logic [4:0] c);
      logic [4:0] r;
      r = 5'h00;
      if (c[4]) begin
         r[4] = 1'b1;
      end else begin
         r[{c[0], ~c[3]}] = 1'b1;
      end
      return r;
   endfunction : chan_neg
endpackage : adcd_pkg

/* src/adcd_shift_if.sv */
// interface between the control logic and the input word shifter
interface adcd_shift_if;
   logic rise;
   logic fall;
   logic clear;
   logic din;
   logic [12:0] word;
   logic [5:0] rise_cnt;
   logic [5:0] fall_cnt;
   modport ctl (output rise, output fall, output clear, output din,
      input word, input rise_cnt, input fall_cnt);
   modport shf (input rise, input fall, input clear, input din,
      output word, output rise_cnt, output fall_cnt);
endinterface : adcd_shift_if

/* src/adcd_shifter.sv */
// shadow storage for the serial configuration word and edge counts
module adcd_shifter (
   input wire logic pclk,
   input wire logic presetn,
   adcd_shift_if.shf sh
);
   logic [12:0] word_q, word_d;
   logic [5:0] rc_q, rc_d;
   logic [5:0] fc_q, fc_d;
   logic [3:0] idx;

   // =============================================
   // next values
   always_comb begin
      word_d = word_q;
      rc_d = rc_q;
      fc_d = fc_q;
      idx = 4'(adcd_pkg::WORD_BITS - 1) - rc_q[3:0];
      if (sh.clear) begin
         word_d = 13'h0000;
         rc_d = 6'h00;
         fc_d = 6'h00;
      end else begin
         if (sh.rise && rc_q < 6'(adcd_pkg::WORD_BITS)) begin
            word_d[idx] = sh.din;
         end
         if (sh.rise && rc_q != 6'h3F) begin
            rc_d = rc_q + 6'h01;
         end
         if (sh.fall && fc_q != 6'h3F) begin
            fc_d = fc_q + 6'h01;
         end
      end
   end

   // =============================================
   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_q <= 13'h0000;
         rc_q <= 6'h00;
         fc_q <= 6'h00;
      end else begin
         word_q <= word_d;
         rc_q <= rc_d;
         fc_q <= fc_d;
      end
   end

   assign sh.word = word_q;
   assign sh.rise_cnt = rc_q;
   assign sh.fall_cnt = fc_q;
endmodule : adcd_shifter

/* src/adcd_top.sv */
// serial configuration decoder, conversion sequencer and apb slave
//
// The APB register port and the placing of the registers are this design's own decisions.
module adcd_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sck_pin,
   input wire logic chip_sel_n,
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   output logic serial_out_oe,
   output logic [4:0] pos_sel,
   output logic [4:0] neg_sel,
   output logic temp_mode,
   output logic [1:0] reject_mode,
   output logic rate_double,
   output logic auto_cal,
   output logic converting
);
   // =============================================
   // pin synchronisers
   logic sck_s1_q, sck_s2_q, sck_s3_q;
   logic cs_s1_q, cs_s2_q;
   logic din_s1_q, din_s2_q;
   logic sck_rise, sck_fall, cs_low;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_s1_q <= 1'b0;
         sck_s2_q <= 1'b0;
         sck_s3_q <= 1'b0;
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         din_s1_q <= 1'b0;
         din_s2_q <= 1'b0;
      end else begin
         sck_s1_q <= sck_pin;
         sck_s2_q <= sck_s1_q;
         sck_s3_q <= sck_s2_q;
         cs_s1_q <= chip_sel_n;
         cs_s2_q <= cs_s1_q;
         din_s1_q <= serial_in_pin;
         din_s2_q <= din_s1_q;
      end
   end

   assign sck_rise = sck_s2_q & ~sck_s3_q;
   assign sck_fall = ~sck_s2_q & sck_s3_q;
   assign cs_low = ~cs_s2_q;

   // =============================================
   // shadow word storage
   adcd_shift_if sh ();

   adcd_shifter u_shifter (
      .pclk(pclk),
      .presetn(presetn),
      .sh(sh.shf)
   );

   adcd_pkg::adcd_state_type state_q, state_d;

   assign sh.rise = sck_rise & cs_low & (state_q != adcd_pkg::st_convert);
   assign sh.fall = sck_fall & cs_low & (state_q == adcd_pkg::st_io);
   assign sh.din = din_s2_q;

   // =============================================
   // apb slave
   logic [29:0] result_q, result_d;
   logic [31:0] prdata_q, prdata_d;
   logic err_q, err_d;
   logic [4:0] act_chan_q, act_chan_d;
   logic act_temp_q, act_temp_d;
   logic act_rhi_q, act_rhi_d;
   logic act_rlo_q, act_rlo_d;
   logic act_rate_q, act_rate_d;

   always_comb begin
      result_d = result_q;
      prdata_d = prdata_q;
      err_d = err_q;
      if (psel && !penable) begin
         err_d = 1'b0;
         case (paddr)
            adcd_pkg::ADDR_STATUS: begin
               prdata_d = {29'h00000000, state_q == adcd_pkg::st_io,
                  state_q == adcd_pkg::st_sleep,
                  state_q == adcd_pkg::st_convert};
            end
            adcd_pkg::ADDR_RESULT: begin
               prdata_d = {2'h0, result_q};
            end
            adcd_pkg::ADDR_SHADOW: begin
               prdata_d = {2'h0, sh.rise_cnt, 2'h0, sh.fall_cnt,
                  3'h0, sh.word};
            end
            adcd_pkg::ADDR_ACTIVE: begin
               prdata_d = {20'h00000, act_rate_q, act_rlo_q, act_rhi_q,
                  act_temp_q, 3'h0, act_chan_q};
            end
            default: begin
               prdata_d = 32'h00000000;
               err_d = 1'b1;
            end
         endcase
      end
      if (psel && penable && pwrite && paddr == adcd_pkg::ADDR_RESULT) begin
         result_d = pwdata[29:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_q <= 30'h00000000;
         prdata_q <= 32'h00000000;
         err_q <= 1'b0;
      end else begin
         result_q <= result_d;
         prdata_q <= prdata_d;
         err_q <= err_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = penable;
   assign pslverr = psel & penable & err_q;

   // =============================================
   // conversion sequencer
   logic [adcd_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic [31:0] shout_q, shout_d;
   logic [31:0] frame_new;
   logic [5:0] falls_eff;
   logic lead_ok, chan_ok, cfg_ok, start_conv, rate_next;
   logic so_q, so_d, oe_q;

   always_comb begin
      frame_new = {2'h0, result_q};
      if (rate_double && result_q[29:28] == 2'h0) begin
         frame_new = (frame_new & adcd_pkg::UNDER_AND) |
            adcd_pkg::UNDER_OR;
      end
   end

   assign falls_eff = sh.fall_cnt + {5'h00, sh.fall};
   assign lead_ok = sh.word[12:10] == adcd_pkg::LEAD_LOAD;
   assign chan_ok = lead_ok && falls_eff >= adcd_pkg::CHAN_LOAD_FALLS;
   assign cfg_ok = chan_ok && sh.word[adcd_pkg::POS_CFG_EN] &&
      falls_eff >= adcd_pkg::CFG_LOAD_FALLS;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      shout_d = shout_q;
      start_conv = 1'b0;
      act_chan_d = act_chan_q;
      act_temp_d = act_temp_q;
      act_rhi_d = act_rhi_q;
      act_rlo_d = act_rlo_q;
      act_rate_d = act_rate_q;
      unique case (state_q)
         adcd_pkg::st_convert: begin
            if (cnt_q == '0) begin
               state_d = adcd_pkg::st_sleep;
               shout_d = frame_new;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         adcd_pkg::st_sleep: begin
            if (cs_low && sck_rise) begin
               state_d = adcd_pkg::st_io;
            end
         end
         adcd_pkg::st_io: begin
            if (sh.fall) begin
               shout_d = {shout_q[30:0], 1'b0};
            end
            if (!cs_low || falls_eff == adcd_pkg::FRAME_FALLS) begin
               start_conv = 1'b1;
            end
         end
      endcase
      if (start_conv) begin
         if (chan_ok) begin
            act_chan_d = sh.word[adcd_pkg::POS_CHAN_HI:adcd_pkg::POS_CHAN_LO];
         end
         if (cfg_ok) begin
            act_temp_d = sh.word[adcd_pkg::POS_TEMP];
            act_rhi_d = sh.word[adcd_pkg::POS_REJ_HI];
            act_rlo_d = sh.word[adcd_pkg::POS_REJ_LO];
            act_rate_d = sh.word[adcd_pkg::POS_RATE];
         end
         state_d = adcd_pkg::st_convert;
         cnt_d = (act_rate_d && !act_temp_d) ? adcd_pkg::CONV_LOAD_2X :
            adcd_pkg::CONV_LOAD_1X;
      end
      so_d = (state_d == adcd_pkg::st_convert) ? 1'b1 : shout_d[31];
   end

   assign rate_next = act_rate_d & ~act_temp_d;
   assign sh.clear = start_conv;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= adcd_pkg::st_convert;
         cnt_q <= adcd_pkg::CONV_LOAD_1X;
         shout_q <= 32'h00000000;
         act_chan_q <= adcd_pkg::RST_CHAN;
         act_temp_q <= adcd_pkg::RST_TEMP;
         act_rhi_q <= adcd_pkg::RST_REJ_HI;
         act_rlo_q <= adcd_pkg::RST_REJ_LO;
         act_rate_q <= adcd_pkg::RST_RATE;
         so_q <= 1'b1;
         oe_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         shout_q <= shout_d;
         act_chan_q <= act_chan_d;
         act_temp_q <= act_temp_d;
         act_rhi_q <= act_rhi_d;
         act_rlo_q <= act_rlo_d;
         act_rate_q <= act_rate_d;
         so_q <= so_d;
         oe_q <= cs_low;
      end
   end

   assign serial_out_pin = so_q;
   assign serial_out_oe = oe_q;
   assign converting = state_q == adcd_pkg::st_convert;

   // =============================================
   // decoded mux and mode outputs
   logic [4:0] pos_q, neg_q;
   logic [1:0] rej_q;
   logic temp_q, dbl_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_q <= 5'h01;
         neg_q <= 5'h02;
         rej_q <= 2'h0;
         temp_q <= 1'b0;
         dbl_q <= 1'b0;
      end else begin
         pos_q <= adcd_pkg::chan_pos(act_chan_d);
         neg_q <= adcd_pkg::chan_neg(act_chan_d);
         rej_q <= {act_rhi_d, act_rlo_d};
         temp_q <= act_temp_d;
         dbl_q <= rate_next;
      end
   end

   assign pos_sel = pos_q;
   assign neg_sel = neg_q;
   assign temp_mode = temp_q;
   assign reject_mode = rej_q;
   assign rate_double = dbl_q;
   assign auto_cal = ~dbl_q;

   // =============================================
   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence seq_conv_end;
      state_q == adcd_pkg::st_convert && cnt_q == '0;
   endsequence

   sequence seq_start;
      start_conv;
   endsequence

   AST_RESET_DEFAULTS: assert property (
      !$past(presetn) |-> act_chan_q == adcd_pkg::RST_CHAN && !act_temp_q
         && !act_rhi_q && !act_rlo_q && !act_rate_q)
      else $error("reset configuration wrong");

   AST_FIRST_CONV: assert property (
      !$past(presetn) |-> state_q == adcd_pkg::st_convert && so_q)
      else $error("no conversion after reset");

   AST_IGNORE_WORD: assert property (
      seq_start and !lead_ok |=> act_chan_q == $past(act_chan_q)
         && act_rate_q == $past(act_rate_q)
         && act_temp_q == $past(act_temp_q))
      else $error("ignored word changed settings");

   AST_CHAN_LOAD: assert property (
      seq_start and chan_ok |=> act_chan_q == $past(sh.word[9:5]))
      else $error("channel not loaded");

   AST_CFG_KEEP: assert property (
      seq_start and !cfg_ok |=> act_rhi_q == $past(act_rhi_q)
         && act_rlo_q == $past(act_rlo_q) && act_rate_q == $past(act_rate_q))
      else $error("configuration changed without enable");

   AST_CONV_LEN: assert property (
      seq_start |=> cnt_q == (rate_next ? adcd_pkg::CONV_LOAD_2X :
         adcd_pkg::CONV_LOAD_1X) ##1 cnt_q == $past(cnt_q) - 1'b1)
      else $error("conversion length wrong");

   AST_EOC_LOW: assert property (
      seq_conv_end |=> !so_q && state_q == adcd_pkg::st_sleep)
      else $error("end of conversion flag not low");

   AST_UNDER: assert property (
      seq_conv_end and (rate_double && result_q[29:28] == 2'h0)
         |=> shout_q[31:12] == 20'h0FFFF)
      else $error("2x underrange code wrong");

   AST_FRAME: assert property (
      seq_conv_end and !(rate_double && result_q[29:28] == 2'h0)
         |=> shout_q[28:5] == $past(result_q[28:5]))
      else $error("result bits misplaced");

   AST_TEMP_1X: assert property (
      temp_mode |-> !rate_double && auto_cal)
      else $error("temperature not at 1x");
endmodule : adcd_top

/* sim/adcd_host_model.sv */
// serial host model: drives clock, select and data, captures frames
module adcd_host_model (
   input wire logic pclk,
   input wire logic dev_out,
   output logic sck,
   output logic cs_n,
   output logic dev_in,
   output logic frame_done,
   output logic [31:0] frame_data,
   output logic eoc_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic act;
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      dev_in = 1'b0;
      act = 1'b0;
      frame_done = 1'b0;
      frame_data = 32'h0;
      eoc_busy = 1'b0;
   end
   // =============================================
   // idle data line toggles so no stale bit survives
   always @(posedge pclk) begin
      if (!act) begin
         dev_in <= ~dev_in;
      end
   end
   // =============================================
   // one transfer of nf clock pulses, clock idles low
   task automatic xfer(input logic [12:0] w, input logic [31:0] fill,
      input int nf);
      logic [31:0] fr;
      int i;
      fr = 32'h0;
      @(posedge pclk);
      act <= 1'b1;
      cs_n <= 1'b0;
      repeat (8) @(posedge pclk);
      fr[31] = dev_out;
      for (i = 0; i < nf; i++) begin
         dev_in <= (i < 13) ? w[12 - i] : fill[i];
         repeat (4) @(posedge pclk);
         sck <= 1'b1;
         repeat (4) @(posedge pclk);
         if (i > 0) begin
            fr[31 - i] = dev_out;
         end
         sck <= 1'b0;
      end
      repeat (8) @(posedge pclk);
      eoc_busy <= dev_out;
      cs_n <= 1'b1;
      act <= 1'b0;
      if (nf == 32) begin
         frame_data <= fr;
         frame_done <= 1'b1;
         @(posedge pclk);
         frame_done <= 1'b0;
      end
   endtask : xfer
endmodule : adcd_host_model

/* sim/tb_top.sv */
// self-checking bench for the serial configuration decoder
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [12:0] WORDS [10] = '{13'h1432, 13'h1515, 13'h172F,
      13'h1639, 13'h13F6, 13'h0131, 13'h1710, 13'h1613, 13'h1411, 13'h1438};
   localparam int FALLS [10] = '{32, 32, 32, 32, 32, 32, 12, 5, 32, 32};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, frame_data, seed;
   logic sck_pin, chip_sel_n, serial_in_pin, serial_out_pin, serial_out_oe;
   logic temp_mode, rate_double, auto_cal, converting, frame_done, eoc_busy;
   logic [4:0] pos_sel, neg_sel;
   logic [1:0] reject_mode;
   logic conv_prev;
   wire dev_out_w;
   wire [14:0] set_w;
   int fail_count;
   int num_checks;
   logic [31:0] frame_q[$];
   logic [14:0] set_q[$];
   assign dev_out_w = serial_out_oe ? serial_out_pin : 1'bz;
   assign set_w = {pos_sel, neg_sel, temp_mode, reject_mode, rate_double,
      auto_cal};
   adcd_top adcd_top_i (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sck_pin(sck_pin), .chip_sel_n(chip_sel_n),
      .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
      .serial_out_oe(serial_out_oe), .pos_sel(pos_sel), .neg_sel(neg_sel),
      .temp_mode(temp_mode), .reject_mode(reject_mode),
      .rate_double(rate_double), .auto_cal(auto_cal),
      .converting(converting)
   );
   adcd_host_model adcd_host_model_i (
      .pclk(pclk), .dev_out(dev_out_w), .sck(sck_pin), .cs_n(chip_sel_n),
      .dev_in(serial_in_pin), .frame_done(frame_done),
      .frame_data(frame_data), .eoc_busy(eoc_busy)
   );
   initial begin
      pclk = 1'b0;
      forever begin
         #25 pclk = ~pclk;
      end
   end
   // =============================================
   // helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   function automatic logic [14:0] exp_set(input logic [4:0] c,
      input logic [3:0] g);
      logic [4:0] p;
      logic [4:0] n;
      logic rd;
      p = 5'h01 << {c[0], c[3]};
      n = c[4] ? 5'h10 : (5'h01 << {c[0], ~c[3]});
      rd = g[0] & ~g[3];
      return {p, n, g[3], g[2:1], rd, ~rd};
   endfunction : exp_set

   task automatic results();
      $display("checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results

   task automatic chk_word(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk_word

   task automatic chk_set(input string what, input logic [14:0] exp,
      input logic [14:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk_set

   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fail_count++;
         results();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_idle();
      int n;
      n = 0;
      while (converting !== 1'b0 && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      if (converting !== 1'b0) begin
         fail_count++;
         results();
      end
   endtask : wait_idle
   // =============================================
   // watchers take the oldest expectation when a result shows
   always @(posedge pclk) begin
      if (frame_done === 1'b1 && frame_q.size() > 0) begin
         chk_word("frame", frame_q.pop_front(), frame_data);
         chk_word("busy flag", 32'h1, {31'h0, eoc_busy});
      end
   end

   always @(posedge pclk) begin
      conv_prev <= converting;
      if (converting === 1'b1 && conv_prev === 1'b0 && set_q.size() > 0)
      begin
         repeat (2) @(posedge pclk);
         chk_set("settings", set_q.pop_front(), set_w);
      end
   end
   // =============================================
   // main sequence
   initial begin
      int i;
      logic [31:0] r, d, f;
      logic e;
      logic [4:0] chan;
      logic [3:0] cfg;
      logic [14:0] es;
      seed = 32'h000147DB;
      fail_count = 0;
      num_checks = 0;
      conv_prev = 1'b1;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      chan = 5'h00;
      cfg = 4'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk_set("reset settings", exp_set(chan, cfg), set_w);
      chk_word("converting", 32'h1, {31'h0, converting});
      apb(1'b0, 8'h10, 32'h0, d, e);
      chk_word("unmapped data", 32'h0, d);
      chk_word("unmapped error", 32'h1, {31'h0, e});
      apb(1'b1, 8'h00, 32'hFFFFFFFF, d, e);
      apb(1'b0, 8'h00, 32'h0, d, e);
      chk_word("status busy", 32'h1, d);
      for (i = 0; i < 10; i++) begin
         r = rnd() & 32'h3FFFFFFF;
         if (i % 2 == 1) begin
            r[29:28] = 2'b00;
         end
         apb(1'b1, 8'h04, r, d, e);
         apb(1'b0, 8'h04, 32'h0, d, e);
         chk_word("result reg", r, d);
         wait_idle();
         apb(1'b0, 8'h00, 32'h0, d, e);
         chk_word("status idle", 32'h2, d);
         es = exp_set(chan, cfg);
         f = r;
         if (es[1] && f[29:28] == 2'b00) begin
            f = (f & 32'h00000FFF) | 32'h0FFFF000;
         end
         if (FALLS[i] == 32) begin
            frame_q.push_back(f);
         end
         if (WORDS[i][12:10] == 3'h5 && FALLS[i] >= 8) begin
            chan = WORDS[i][9:5];
         end
         if (WORDS[i][12:10] == 3'h5 && WORDS[i][4] && FALLS[i] >= 16) begin
            cfg = WORDS[i][3:0];
         end
         set_q.push_back(exp_set(chan, cfg));
         adcd_host_model_i.xfer(WORDS[i], rnd(), FALLS[i]);
         repeat (8) @(posedge pclk);
         apb(1'b0, 8'h0C, 32'h0, d, e);
         f = {20'h0, cfg[0], cfg[1], cfg[2], cfg[3], 3'h0, chan};
         chk_word("active", f, d);
      end
      repeat (4) @(posedge pclk);
      chk_word("frames left", 32'h0, 32'(frame_q.size()));
      chk_word("settings left", 32'h0, 32'(set_q.size()));
      results();
   end
endmodule : tb_top
